// [rtl/misc_sfr_bank.sv]
`timescale 1ns/100ps
`default_nettype none
// Function
// - Pointer high and low bytes form 16-bit pointer.
// - Pointer select bit chooses active data pointer.
// - ADC base is high nibble plus low byte.
// - Low reload byte gives reload bits 7:0.
// - High reload byte gives reload bits 15:8.
// - Double-rate bit doubles serial baud rate in mode 2, and in modes 1 and 3 when timer 1 paces the port.
// - Framing select steers serial control bit 7.
// - Power-on sets flag; other resets keep it.
module misc_sfr_bank (
    // Clock and resets.
    input  wire logic                       core_clk,
    input  wire logic                       rstn,
    input  wire logic                       por_n,
    // Special-register bus.
    input  wire misc_sfr_pkg::sfr_req_s     sfr_req,
    output logic [7:0]                      sfr_rdata_q,
    output logic                            sfr_hit_q,
    // Data pointer.
    input  wire logic                       pointer_select,
    output logic [15:0]                     active_pointer_q,
    // ADC and wake-up timer values.
    output logic [11:0]                     adc_ram_base,
    output logic [15:0]                     wakeup_reload_value,
    // Power byte bits.
    output logic                            double_rate_bit,
    output logic                            framing_access_select,
    output logic                            power_on_flag,
    // Serial port 0 side.
    input  wire misc_sfr_pkg::serial_mode_e serial_mode,
    input  wire logic                       timer1_baud_src,
    input  wire misc_sfr_pkg::serial_control_bit_s    serial_control_bit,
    input  wire logic                       mode_bit_cur,
    input  wire logic                       frame_err_cur,
    output logic                            baud_double_q,
    output logic                            mode_bit_wr_q,
    output logic                            frame_err_wr_q,
    output logic                            serial_control_wbit_q,
    output logic                            bit7_rdata_q
);

    // Register state.
    logic [7:0] ptr_low_q  [2];      // Low bytes of the primary and secondary pointers.
    logic [7:0] ptr_high_q [2];      // High bytes of the primary and secondary pointers.
    logic [3:0] adc_high_q;          // ADC base bits 11:8.
    logic [7:0] adc_low_q;           // ADC base bits 7:0.
    logic [7:0] reload_low_q;        // Wake-up reload bits 7:0.
    logic [7:0] reload_high_q;       // Wake-up reload bits 15:8.
    logic       double_q;            // Double-rate bit.
    logic       frame_sel_q;         // Framing-access select bit.
    logic       power_on_q;          // Power-on flag.

    // Address decode; the paged registers answer only on their page.
    wire on_page_two  = (sfr_req.page == misc_sfr_pkg::PAGE_TWO);
    wire on_page_zero = (sfr_req.page == misc_sfr_pkg::PAGE_ZERO);
    wire sel_ptr_low  = (sfr_req.addr == misc_sfr_pkg::ADDR_PTR_LOW);
    wire sel_ptr_high = (sfr_req.addr == misc_sfr_pkg::ADDR_PTR_HIGH);
    wire sel_adc_high = (sfr_req.addr == misc_sfr_pkg::ADDR_ADC_HIGH) && on_page_two;
    wire sel_adc_low  = (sfr_req.addr == misc_sfr_pkg::ADDR_ADC_LOW) && on_page_two;
    wire sel_rel_low  = (sfr_req.addr == misc_sfr_pkg::ADDR_RELOAD_LOW) && on_page_zero;
    wire sel_rel_high = (sfr_req.addr == misc_sfr_pkg::ADDR_RELOAD_HIGH) && on_page_two;
    wire sel_power    = (sfr_req.addr == misc_sfr_pkg::ADDR_POWER);
    wire sel_any      = sel_ptr_low || sel_ptr_high || sel_adc_high || sel_adc_low
                      || sel_rel_low || sel_rel_high || sel_power;

    // Write strobes per register.
    wire wr_ptr_low  = sfr_req.wr && sel_ptr_low;
    wire wr_ptr_high = sfr_req.wr && sel_ptr_high;
    wire wr_adc_high = sfr_req.wr && sel_adc_high;
    wire wr_adc_low  = sfr_req.wr && sel_adc_low;
    wire wr_rel_low  = sfr_req.wr && sel_rel_low;
    wire wr_rel_high = sfr_req.wr && sel_rel_high;
    wire wr_power    = sfr_req.wr && sel_power;

    // The pointer seen at the pointer addresses is the one chosen by the select.
    wire [7:0]  cur_ptr_low  = ptr_low_q[pointer_select];
    wire [7:0]  cur_ptr_high = ptr_high_q[pointer_select];
    wire [15:0] cur_pointer  = {cur_ptr_high, cur_ptr_low};

    // Power byte as read: bit 5 and the bits kept elsewhere read zero.
    wire [7:0] power_read = (8'(double_q) << misc_sfr_pkg::DOUBLE_BIT)
                          | (8'(frame_sel_q) << misc_sfr_pkg::FRAME_SEL_BIT)
                          | (8'(power_on_q) << misc_sfr_pkg::POWER_ON_BIT);

    // Read multiplexer; an unmapped address reads zero.
    wire [7:0] rdata_d = ({8{sel_ptr_low}}  & cur_ptr_low)
                       | ({8{sel_ptr_high}} & cur_ptr_high)
                       | ({8{sel_adc_high}} & {4'h0, adc_high_q})
                       | ({8{sel_adc_low}}  & adc_low_q)
                       | ({8{sel_rel_low}}  & reload_low_q)
                       | ({8{sel_rel_high}} & reload_high_q)
                       | ({8{sel_power}}    & power_read);

    // Read data and hit are registered one cycle after the read strobe.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sfr_rdata_q <= misc_sfr_pkg::RESET_BYTE;
            sfr_hit_q   <= 1'b0;
        end else begin
            sfr_rdata_q <= sfr_req.rd ? rdata_d : misc_sfr_pkg::RESET_BYTE;
            sfr_hit_q   <= sfr_req.rd && sel_any;
        end
    end

    // Both pointers; a write reaches only the currently selected one.
    for (genvar i = 0; i < 2; i++) begin : g_ptr
        wire hit_me = (pointer_select == 1'(i));
        always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
                ptr_low_q[i]  <= misc_sfr_pkg::RESET_BYTE;
                ptr_high_q[i] <= misc_sfr_pkg::RESET_BYTE;
            end else begin
                if (wr_ptr_low && hit_me) ptr_low_q[i] <= sfr_req.wdata;
                if (wr_ptr_high && hit_me) ptr_high_q[i] <= sfr_req.wdata;
            end
        end
    end

    // The active pointer is presented from a flop, one cycle behind the bytes.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) active_pointer_q <= {misc_sfr_pkg::RESET_BYTE, misc_sfr_pkg::RESET_BYTE};
        else       active_pointer_q <= cur_pointer;
    end

    // ADC base and wake-up reload bytes.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            adc_high_q    <= misc_sfr_pkg::RESET_BYTE[misc_sfr_pkg::ADC_HIGH_WIDTH-1:0];
            adc_low_q     <= misc_sfr_pkg::RESET_BYTE;
            reload_low_q  <= misc_sfr_pkg::RESET_BYTE;
            reload_high_q <= misc_sfr_pkg::RESET_BYTE;
        end else begin
            if (wr_adc_high) adc_high_q <= sfr_req.wdata[misc_sfr_pkg::ADC_HIGH_WIDTH-1:0];
            if (wr_adc_low)  adc_low_q <= sfr_req.wdata;
            if (wr_rel_low)  reload_low_q <= sfr_req.wdata;
            if (wr_rel_high) reload_high_q <= sfr_req.wdata;
        end
    end
    assign adc_ram_base        = {adc_high_q, adc_low_q};
    assign wakeup_reload_value = {reload_high_q, reload_low_q};

    // Double-rate and framing select clear on rstn only; the power-on reset alone keeps them.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            double_q    <= misc_sfr_pkg::POWER_COLD_VALUE[misc_sfr_pkg::DOUBLE_BIT];
            frame_sel_q <= misc_sfr_pkg::POWER_COLD_VALUE[misc_sfr_pkg::FRAME_SEL_BIT];
        end else if (wr_power) begin
            double_q    <= sfr_req.wdata[misc_sfr_pkg::DOUBLE_BIT];
            frame_sel_q <= sfr_req.wdata[misc_sfr_pkg::FRAME_SEL_BIT];
        end
    end

    // The power-on flag sees only the power-on reset, so a warm reset keeps it.
    always_ff @(posedge core_clk or negedge por_n) begin
        if (!por_n)        power_on_q <= misc_sfr_pkg::POWER_COLD_VALUE[misc_sfr_pkg::POWER_ON_BIT];
        else if (wr_power) power_on_q <= sfr_req.wdata[misc_sfr_pkg::POWER_ON_BIT];
    end
    assign double_rate_bit       = double_q;
    assign framing_access_select = frame_sel_q;
    assign power_on_flag         = power_on_q;

    // Serial steering results before their output flops.
    logic baud_double_d;
    logic mode_bit_wr_d;
    logic frame_err_wr_d;
    logic bit7_rdata_d;

    // Baud doubling and bit 7 routing.
    serial_bit_steer u_steer (
        .double_rate_bit       (double_q),
        .framing_access_select (frame_sel_q),
        .serial_mode           (serial_mode),
        .timer1_baud_src       (timer1_baud_src),
        .serial_control_bit              (serial_control_bit),
        .mode_bit_cur          (mode_bit_cur),
        .frame_err_cur         (frame_err_cur),
        .baud_double           (baud_double_d),
        .mode_bit_wr           (mode_bit_wr_d),
        .frame_err_wr          (frame_err_wr_d),
        .bit7_rdata            (bit7_rdata_d)
    );

    // Steering outputs leave from flops, one cycle after their cause.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            baud_double_q  <= 1'b0;
            mode_bit_wr_q  <= 1'b0;
            frame_err_wr_q <= 1'b0;
            serial_control_wbit_q    <= 1'b0;
            bit7_rdata_q   <= 1'b0;
        end else begin
            baud_double_q  <= baud_double_d;
            mode_bit_wr_q  <= mode_bit_wr_d;
            frame_err_wr_q <= frame_err_wr_d;
            serial_control_wbit_q    <= serial_control_bit.wbit;
            bit7_rdata_q   <= bit7_rdata_d;
        end
    end

    // Checks on the bank's own behaviour.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_ptr_high_join: assert property (
        (wr_ptr_high && !pointer_select) ##1 (!pointer_select && !wr_ptr_high)
        |=> active_pointer_q[15:8] == $past(sfr_req.wdata, 2))
        else $error("Pointer high byte not joined into active pointer.");
    a_ptr_select_keep: assert property (
        (wr_ptr_low && pointer_select) |=> ptr_low_q[0] == $past(ptr_low_q[0]))
        else $error("Write to secondary pointer disturbed primary pointer.");
    a_adc_high_nibble: assert property (
        wr_adc_high |=> adc_ram_base[11:8] == $past(sfr_req.wdata[3:0]))
        else $error("ADC base high nibble not taken from write.");
    a_reload_low_byte: assert property (
        wr_rel_low |=> wakeup_reload_value[7:0] == $past(sfr_req.wdata))
        else $error("Reload low byte not taken from write.");
    a_reload_high_byte: assert property (
        wr_rel_high |=> wakeup_reload_value[15:8] == $past(sfr_req.wdata))
        else $error("Reload high byte not taken from write.");
    a_baud_mode_two: assert property (
        (double_q && serial_mode == misc_sfr_pkg::SERIAL_MODE_2) |=> baud_double_q)
        else $error("Baud rate not doubled in mode 2.");
    a_baud_off: assert property (
        !double_q |=> !baud_double_q)
        else $error("Baud rate doubled with double-rate bit clear.");
    a_bit7_route: assert property (
        (serial_control_bit.wr && frame_sel_q) |=> frame_err_wr_q && !mode_bit_wr_q)
        else $error("Bit 7 write not steered to framing flag.");
    a_warm_keeps_flag: assert property (
        @(posedge core_clk) disable iff (!por_n)
        !rstn |=> power_on_flag == $past(power_on_flag))
        else $error("Power-on flag changed during warm reset.");
    a_reserved_zero: assert property (
        (sfr_req.rd && (sel_adc_high || sel_power)) |=> sfr_rdata_q[5] == 1'b0
        && (!$past(sel_adc_high) || sfr_rdata_q[7:4] == 4'h0))
        else $error("Reserved bits read non-zero.");

    c_ptr_swap:    cover property (wr_ptr_high ##1 $changed(pointer_select));
    c_power_clear: cover property (power_on_q ##1 wr_power ##1 !power_on_q);
    c_frame_write: cover property (serial_control_bit.wr && frame_sel_q);

endmodule // misc_sfr_bank
`default_nettype wire

// [rtl/misc_sfr_pkg.sv]
`default_nettype none
// Shared constants and carriers of the pointer, ADC base, wake-up reload and power byte bank.
package misc_sfr_pkg;

    // Special-register addresses of the bank.
    localparam logic [7:0] ADDR_PTR_LOW     = 8'h82;  // Active pointer, low byte, all pages.
    localparam logic [7:0] ADDR_PTR_HIGH    = 8'h83;  // Active pointer, high byte, all pages.
    localparam logic [7:0] ADDR_ADC_HIGH    = 8'h84;  // ADC RAM base, high nibble, page 2.
    localparam logic [7:0] ADDR_ADC_LOW     = 8'h85;  // ADC RAM base, low byte, page 2.
    localparam logic [7:0] ADDR_RELOAD_LOW  = 8'h86;  // Wake-up reload, low byte, page 0.
    localparam logic [7:0] ADDR_POWER       = 8'h87;  // Power control, all pages.
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h97;  // Wake-up reload, high byte, page 2.

    // Page numbers used by the paged registers.
    localparam logic [1:0] PAGE_ZERO = 2'h0;  // Page 0.
    localparam logic [1:0] PAGE_TWO  = 2'h2;  // Page 2.

    // Reset values and field layout.
    localparam logic [7:0] RESET_BYTE       = 8'h00;  // Reset value of every plain byte.
    localparam logic [7:0] POWER_COLD_VALUE = 8'h10;  // Power byte after a power-on reset.
    localparam logic [7:0] ADC_HIGH_MASK    = 8'h0f;  // Implemented bits of the ADC high byte.
    localparam int unsigned DOUBLE_BIT      = 7;      // Double-rate bit position.
    localparam int unsigned FRAME_SEL_BIT   = 6;      // Framing-access select bit position.
    localparam int unsigned POWER_ON_BIT    = 4;      // Power-on flag bit position.
    localparam int unsigned ADC_HIGH_WIDTH  = 4;      // Width of the ADC base high part.

    // Serial port 0 operating modes.
    typedef enum logic [1:0] {
        SERIAL_MODE_0 = 2'b00,
        SERIAL_MODE_1 = 2'b01,
        SERIAL_MODE_2 = 2'b10,
        SERIAL_MODE_3 = 2'b11
    } serial_mode_e;

    // One access from the core's special-register bus.
    typedef struct packed {
        logic [7:0] addr;   // Register address.
        logic [1:0] page;   // Current page.
        logic       wr;     // Write strobe, one cycle.
        logic       rd;     // Read strobe, one cycle.
        logic [7:0] wdata;  // Write data.
    } sfr_req_s;

    // The serial control bit 7 access from the core.
    typedef struct packed {
        logic wr;     // Write strobe to serial control bit 7.
        logic wbit;   // Value written.
    } serial_control_bit_s;

endpackage
`default_nettype wire

// [rtl/serial_bit_steer.sv]
`timescale 1ns/100ps
`default_nettype none
// Decides the doubled baud rate and routes serial control bit 7 accesses.
module serial_bit_steer (
    // Controls from the power byte.
    input  wire logic                       double_rate_bit,
    input  wire logic                       framing_access_select,
    // Serial port state.
    input  wire misc_sfr_pkg::serial_mode_e serial_mode,
    input  wire logic                       timer1_baud_src,
    input  wire misc_sfr_pkg::serial_control_bit_s    serial_control_bit,
    input  wire logic                       mode_bit_cur,
    input  wire logic                       frame_err_cur,
    // Steered results.
    output logic                            baud_double,
    output logic                            mode_bit_wr,
    output logic                            frame_err_wr,
    output logic                            bit7_rdata
);

    // Mode 2 always doubles; modes 1 and 3 only when timer 1 paces the port.
    wire mode_two   = (serial_mode == misc_sfr_pkg::SERIAL_MODE_2);
    wire mode_t1    = (serial_mode == misc_sfr_pkg::SERIAL_MODE_1)
                    || (serial_mode == misc_sfr_pkg::SERIAL_MODE_3);
    assign baud_double  = double_rate_bit && (mode_two || (mode_t1 && timer1_baud_src));

    // Bit 7 reaches the mode bit when the select is clear, the framing flag when set.
    assign mode_bit_wr  = serial_control_bit.wr && !framing_access_select;
    assign frame_err_wr = serial_control_bit.wr && framing_access_select;
    assign bit7_rdata   = framing_access_select ? frame_err_cur : mode_bit_cur;

endmodule // serial_bit_steer
`default_nettype wire

// [verif/serial_port_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Stands in for serial port 0: it keeps mode bit 0 and the framing flag behind bit 7.
module serial_port_model (
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic rstn,
    // Steered write strobes and the written value from the bank.
    input  wire logic mode_bit_wr_q,
    input  wire logic frame_err_wr_q,
    input  wire logic serial_control_wbit_q,
    // Current bit values that the bank reads back.
    output logic      mode_bit_cur,
    output logic      frame_err_cur
);
    // Each strobe touches only its own bit, so a steering slip shows as a wrong bit.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mode_bit_cur  <= 1'b0;
            frame_err_cur <= 1'b0;
        end else begin
            if (mode_bit_wr_q) mode_bit_cur <= serial_control_wbit_q;
            if (frame_err_wr_q) frame_err_cur <= serial_control_wbit_q;
        end
    end
endmodule // serial_port_model
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
// Drives the bank like the core does and scores reads through a queue of expected bytes.
module tb_top;
    logic core_clk, rstn, por_n, pointer_select, timer1_baud_src;
    logic mode_bit_cur, frame_err_cur, sfr_hit_q, power_on_flag;
    logic double_rate_bit, framing_access_select, baud_double_q, bit7_rdata_q;
    logic mode_bit_wr_q, frame_err_wr_q, serial_control_wbit_q;
    logic [7:0]  sfr_rdata_q;
    logic [15:0] active_pointer_q, wakeup_reload_value;
    logic [11:0] adc_ram_base;
    misc_sfr_pkg::sfr_req_s     sfr_req;
    misc_sfr_pkg::serial_control_bit_s    serial_control_bit;
    misc_sfr_pkg::serial_mode_e serial_mode;
    int n_fail, checks;
    logic [31:0] seed;
    logic [7:0]  exp_q[$];
    logic [7:0]  d[5], e;
    logic [15:0] p[2];
    logic [7:0]  ra[5] = '{8'h83, 8'h84, 8'h85, 8'h86, 8'h97};
    logic [1:0]  rp[5] = '{2'h1, 2'h2, 2'h2, 2'h0, 2'h2};
    logic a, x;
    misc_sfr_bank i_misc_sfr_bank (.core_clk, .rstn, .por_n, .sfr_req, .sfr_rdata_q, .sfr_hit_q,
        .pointer_select, .active_pointer_q, .adc_ram_base, .wakeup_reload_value,
        .double_rate_bit, .framing_access_select, .power_on_flag, .serial_mode,
        .timer1_baud_src, .serial_control_bit, .mode_bit_cur, .frame_err_cur, .baud_double_q,
        .mode_bit_wr_q, .frame_err_wr_q, .serial_control_wbit_q, .bit7_rdata_q);
    serial_port_model i_serial_port_model (.core_clk, .rstn, .mode_bit_wr_q, .frame_err_wr_q,
        .serial_control_wbit_q, .mode_bit_cur, .frame_err_cur);
    // Free-running 100 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Compare tasks, one for each width of result.
    task automatic cmp_byte(input string nm, input logic [7:0] ex, input logic [7:0] got);
        checks++;
        if (got !== ex) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic cmp_word(input string nm, input logic [15:0] ex, input logic [15:0] got);
        checks++;
        if (got !== ex) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic cmp_bit(input string nm, input logic ex, input logic got);
        cmp_word(nm, {15'h0000, ex}, {15'h0000, got});
    endtask
    // One write strobe, held across exactly one rising edge.
    task automatic sfr_wr(input logic [7:0] ad, input logic [1:0] pg, input logic [7:0] wd);
        @(negedge core_clk);
        sfr_req = '{addr: ad, page: pg, wr: 1'b1, rd: 1'b0, wdata: wd};
        @(negedge core_clk);
        sfr_req.wr = 1'b0;
    endtask
    // One read strobe; a mapped read leaves a note, a refused one is checked here.
    task automatic sfr_rd(input logic [7:0] ad, input logic [1:0] pg, input logic [7:0] ex,
                          input bit mapped);
        @(negedge core_clk);
        sfr_req = '{addr: ad, page: pg, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        if (mapped) exp_q.push_back(ex);
        @(negedge core_clk);
        sfr_req.rd = 1'b0;
        if (!mapped) cmp_word("refused read", 16'h0000, {7'h00, sfr_hit_q, sfr_rdata_q});
    endtask
    // Core write of serial control bit 7.
    task automatic serial_control_wr(input logic b);
        @(negedge core_clk);
        serial_control_bit = '{wr: 1'b1, wbit: b};
        @(negedge core_clk);
        serial_control_bit.wr = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask
    // Reset pulse of four cycles; a cold one pulls the power-on reset too.
    task automatic do_reset(input logic cold);
        @(negedge core_clk);
        rstn = 1'b0;
        por_n = ~cold;
        repeat (4) @(negedge core_clk);
        rstn = 1'b1;
        por_n = 1'b1;
    endtask
    task automatic tally_and_finish;
        if (exp_q.size() != 0) n_fail++;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Monitor: every read answer takes the oldest note off the queue.
    always @(negedge core_clk) begin
        if (sfr_hit_q === 1'b1) begin
            if (exp_q.size() == 0) cmp_byte("unasked read", 8'hxx, sfr_rdata_q);
            else cmp_byte("read data", exp_q.pop_front(), sfr_rdata_q);
        end
    end
    // Watchdog at 20000 cycles, far beyond the fewer than 200 cycles the run needs.
    initial begin
        #200000;
        n_fail++;
        tally_and_finish();
    end
    // Main sequence.
    initial begin
        seed = 32'h816c;
        sfr_req = '0;
        serial_control_bit = '0;
        serial_mode = misc_sfr_pkg::SERIAL_MODE_0;
        {pointer_select, timer1_baud_src, rstn, por_n} = 4'h0;
        repeat (4) @(negedge core_clk);
        {rstn, por_n} = 2'b11;
        cmp_bit("power on flag", 1'b1, power_on_flag);
        sfr_rd(misc_sfr_pkg::ADDR_POWER, 2'h3, misc_sfr_pkg::POWER_COLD_VALUE, 1);
        for (int i = 0; i < 5; i++) sfr_rd(ra[i], rp[i], 8'h00, 1);
        // Random bytes everywhere; the high reload byte keeps bit 0 low to avoid all-ones.
        for (int i = 0; i < 5; i++) begin
            d[i] = 8'($random(seed));
            sfr_wr(ra[i], rp[i], d[i]);
        end
        d[4][0] = 1'b0;
        sfr_wr(ra[4], rp[4], d[4]);
        sfr_wr(misc_sfr_pkg::ADDR_RELOAD_LOW, 2'h1, ~d[3]);
        for (int i = 0; i < 5; i++) begin
            e = (i == 1) ? (d[i] & misc_sfr_pkg::ADC_HIGH_MASK) : d[i];
            sfr_rd(ra[i], rp[i], e, 1);
        end
        cmp_word("adc base", {4'h0, d[1][3:0], d[2]}, {4'h0, adc_ram_base});
        cmp_word("reload", {d[4], d[3]}, wakeup_reload_value);
        sfr_rd(8'h88, 2'h0, 8'h00, 0);
        sfr_rd(misc_sfr_pkg::ADDR_RELOAD_HIGH, 2'h0, 8'h00, 0);
        // Two banked pointers written through the same addresses.
        for (int s = 0; s < 2; s++) begin
            pointer_select = s[0];
            p[s] = 16'($random(seed));
            sfr_wr(misc_sfr_pkg::ADDR_PTR_LOW, 2'($random(seed)), p[s][7:0]);
            sfr_wr(misc_sfr_pkg::ADDR_PTR_HIGH, 2'($random(seed)), p[s][15:8]);
        end
        for (int s = 0; s < 2; s++) begin
            pointer_select = s[0];
            repeat (2) @(negedge core_clk);
            cmp_word("pointer", p[s], active_pointer_q);
            sfr_rd(misc_sfr_pkg::ADDR_PTR_HIGH, 2'h0, p[s][15:8], 1);
        end
        sfr_wr(misc_sfr_pkg::ADDR_POWER, 2'h1, 8'hff);
        sfr_rd(misc_sfr_pkg::ADDR_POWER, 2'h2, 8'hd0, 1);
        cmp_word("power bits", 16'h0003, {14'h0000, double_rate_bit, framing_access_select});
        do_reset(1'b0);
        sfr_rd(misc_sfr_pkg::ADDR_POWER, 2'h0, 8'h10, 1);
        cmp_word("reload after reset", 16'h0000, wakeup_reload_value);
        sfr_wr(misc_sfr_pkg::ADDR_POWER, 2'h0, 8'h00);
        do_reset(1'b0);
        cmp_bit("power on flag kept clear", 1'b0, power_on_flag);
        // Every mode, rate bit and baud source combination.
        for (int m = 0; m < 8; m++) begin
            for (int t = 0; t < 2; t++) begin
                sfr_wr(misc_sfr_pkg::ADDR_POWER, 2'h0, {m[2], 7'h00});
                serial_mode = misc_sfr_pkg::serial_mode_e'(m[1:0]);
                timer1_baud_src = t[0];
                repeat (2) @(negedge core_clk);
                x = m[2] && (m[1:0] == 2'h2 || (m[0] && t[0] == 1'b1));
                cmp_bit("baud double", x, baud_double_q);
            end
        end
        a = 1'($random(seed));
        sfr_wr(misc_sfr_pkg::ADDR_POWER, 2'h0, 8'h00);
        serial_control_wr(a);
        cmp_word("serial bits", {14'h0000, a, 1'b0}, {14'h0000, mode_bit_cur, frame_err_cur});
        sfr_wr(misc_sfr_pkg::ADDR_POWER, 2'h0, 8'h40);
        serial_control_wr(~a);
        cmp_word("serial bits", {14'h0000, a, ~a}, {14'h0000, mode_bit_cur, frame_err_cur});
        cmp_bit("bit7 read", ~a, bit7_rdata_q);
        sfr_wr(misc_sfr_pkg::ADDR_POWER, 2'h0, 8'h00);
        repeat (3) @(negedge core_clk);
        cmp_bit("bit7 read", a, bit7_rdata_q);
        // A cold reset in mid-run sets the flag that software cleared earlier.
        do_reset(1'b1);
        cmp_bit("power on flag cold", 1'b1, power_on_flag);
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
